// >>> core/comparator_wake_interrupt.sv
// Comparator output change: wake, flag and vector decision per power mode
// Overview of operation
// - Green/Normal with irq-enable 0: a change raises no interrupt.
// - Sleep/Idle with wake-enable 0: no wake; flag still set if irq-enable.
// - Interrupts disabled, irq-enable 1: set flag, continue, no vector.
// - Green/Normal, interrupts on, irq-enable 1: set flag, vector 0x08.
// - Sleep/Idle, wake 1, irq-enable 1, enabled: wake, flag, vector 0x08.
//
// The plain strobed port and the address map are this design's own decisions.
`default_nettype none
module comparator_wake_interrupt
(
  input  wire logic                      ref_clk,
  input  wire logic                      srst,
  input  wire logic                      cmp_out,
  input  wire cmp_wake_pkg::power_mode_t power_mode,
  input  wire logic                      global_irq_enable_instr,
  input  wire logic                      global_irq_disable_instr,
  input  wire logic [2:0]                reg_addr,
  input  wire logic [7:0]                reg_wdata,
  input  wire logic                      reg_wr,
  input  wire logic                      reg_rd,
  output logic [7:0]                     reg_rdata,
  output logic                           irq,
  output logic                           wake_req,
  output logic                           vector_req,
  output logic                           next_instr,
  output logic [9:0]                     vector_addr,
  output logic                           clock_hold
);
  // Register indices
  localparam logic [2:0] ADDR_WAKE_EN = cmp_wake_pkg::OFS_WAKE_EN;
  localparam logic [2:0] ADDR_IRQ_EN  = cmp_wake_pkg::OFS_IRQ_EN;
  localparam logic [2:0] ADDR_FLAG    = cmp_wake_pkg::OFS_FLAG;
  localparam logic [2:0] ADDR_MASK    = cmp_wake_pkg::OFS_MASK;
  localparam logic [2:0] ADDR_STATUS  = cmp_wake_pkg::OFS_STATUS;

  logic                      cmp_change;
  logic [7:0]                wake_en_q;
  logic [7:0]                wake_en_d;
  logic [7:0]                irq_en_q;
  logic [7:0]                irq_en_d;
  logic                      flag_q;
  logic                      flag_d;
  logic                      gie_q;
  logic                      gie_d;
  logic                      mask_q;
  logic                      mask_d;
  logic                      asleep_q;
  logic                      asleep_d;
  logic [7:0]                rdata_q;
  logic [7:0]                rdata_d;
  logic                      wake_q;
  logic                      wake_d;
  logic                      vec_q;
  logic                      vec_d;
  logic                      next_q;
  logic                      next_d;
  cmp_wake_pkg::cmp_action_t act;

  function automatic logic is_low_power
  (
    input cmp_wake_pkg::power_mode_t m
  );
    is_low_power = (m == cmp_wake_pkg::MODE_SLEEP) ||
                   (m == cmp_wake_pkg::MODE_IDLE);
  endfunction : is_low_power

  cmp_edge_sync u_sync
  (
    .ref_clk  (ref_clk),
    .srst     (srst),
    .async_in (cmp_out),
    .changed  (cmp_change)
  );

  // Decision table for one comparator change
  always_comb
  begin
    act = '0;
    if (cmp_change)
    begin
      if (is_low_power(power_mode))
      begin
        if (!wake_en_q[cmp_wake_pkg::WAKE_EN_BIT])
        begin
          act.set_flag = irq_en_q[cmp_wake_pkg::IRQ_EN_BIT];
        end
        else if (!irq_en_q[cmp_wake_pkg::IRQ_EN_BIT])
        begin
          act.wake       = 1'b1;
          act.next_instr = 1'b1;
        end
        else
        begin
          act.wake       = 1'b1;
          act.set_flag   = 1'b1;
          act.vector     = gie_q;
          act.next_instr = !gie_q;
        end
      end
      else if (irq_en_q[cmp_wake_pkg::IRQ_EN_BIT])
      begin
        act.set_flag   = 1'b1;
        act.vector     = gie_q;
        act.next_instr = !gie_q;
      end
    end
  end

  // Control bits written by software only
  always_comb
  begin
    wake_en_d = wake_en_q;
    irq_en_d  = irq_en_q;
    mask_d    = mask_q;
    if (reg_wr)
    begin
      case (reg_addr)
        ADDR_WAKE_EN:
        begin
          wake_en_d = reg_wdata;
        end
        ADDR_IRQ_EN:
        begin
          irq_en_d = reg_wdata;
        end
        ADDR_MASK:
        begin
          mask_d = reg_wdata[cmp_wake_pkg::FLAG_BIT];
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      wake_en_q <= cmp_wake_pkg::CTRL_RESET;
      irq_en_q  <= cmp_wake_pkg::CTRL_RESET;
      mask_q    <= 1'b0;
    end
    else
    begin
      wake_en_q <= wake_en_d;
      irq_en_q  <= irq_en_d;
      mask_q    <= mask_d;
    end
  end

  // Enable wins when both instructions land in one cycle
  always_comb
  begin
    gie_d = gie_q;
    if (global_irq_enable_instr)
    begin
      gie_d = 1'b1;
    end
    else if (global_irq_disable_instr)
    begin
      gie_d = 1'b0;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      gie_q <= 1'b0;
    end
    else
    begin
      gie_q <= gie_d;
    end
  end

  // Event flag: sticky until software clears it
  always_comb
  begin
    flag_d = flag_q;
    if (reg_wr)
    begin
      case (reg_addr)
        ADDR_FLAG:
        begin
          flag_d = reg_wdata[cmp_wake_pkg::FLAG_BIT];
        end
        ADDR_STATUS:
        begin
          if (reg_wdata[cmp_wake_pkg::FLAG_BIT])
          begin
            flag_d = 1'b0;
          end
        end
        default: ;
      endcase
    end
    // Hardware set wins over a same-cycle clear
    if (act.set_flag)
    begin
      flag_d = 1'b1;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      flag_q <= 1'b0;
    end
    else
    begin
      flag_q <= flag_d;
    end
  end

  // Wake state: asleep in low power except in the one cycle after a waking change
  always_comb
  begin
    asleep_d = is_low_power(power_mode) && !act.wake;
    wake_d   = act.wake;
    vec_d    = act.vector;
    next_d   = act.next_instr;
  end

  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      asleep_q <= 1'b0;
      wake_q   <= 1'b0;
      vec_q    <= 1'b0;
      next_q   <= 1'b0;
    end
    else
    begin
      asleep_q <= asleep_d;
      wake_q   <= wake_d;
      vec_q    <= vec_d;
      next_q   <= next_d;
    end
  end

  // Reads return zero outside the cycle after a read strobe
  always_comb
  begin
    rdata_d = 8'h00;
    if (reg_rd)
    begin
      case (reg_addr)
        ADDR_WAKE_EN:
        begin
          rdata_d = wake_en_q;
        end
        ADDR_IRQ_EN:
        begin
          rdata_d = irq_en_q;
        end
        ADDR_FLAG:
        begin
          rdata_d = {7'h00, flag_q};
        end
        ADDR_MASK:
        begin
          rdata_d = {7'h00, mask_q};
        end
        ADDR_STATUS:
        begin
          rdata_d = {5'h00, asleep_q, gie_q, flag_q};
        end
        default:
        begin
          rdata_d = 8'h00;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      rdata_q <= 8'h00;
    end
    else
    begin
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata   = rdata_q;
  // Level line only in run modes so a sleeping core is not disturbed
  assign irq         = flag_q && mask_q && !is_low_power(power_mode);
  assign wake_req    = wake_q;
  assign vector_req  = vec_q;
  assign next_instr  = next_q;
  assign vector_addr = cmp_wake_pkg::IRQ_VECTOR;
  // Oscillator and timer stay stopped while asleep without a wake
  assign clock_hold  = asleep_q;
endmodule : comparator_wake_interrupt
`default_nettype wire

// >>> core/cmp_wake_pkg.sv
// Constants and types for the comparator wake and interrupt block
`default_nettype none
package cmp_wake_pkg;
  // Power modes of the core
  typedef enum logic [1:0]
  {
    MODE_SLEEP,
    MODE_IDLE,
    MODE_GREEN,
    MODE_NORMAL
  } power_mode_t;

  // Bit positions within the wake-enable and irq-enable control bytes
  localparam int unsigned WAKE_EN_BIT   = 2;
  localparam int unsigned IRQ_EN_BIT    = 0;
  localparam int unsigned FLAG_BIT      = 0;
  localparam int unsigned CTRL_W        = 8;
  localparam int unsigned PC_W          = 10;
  localparam logic [9:0]  IRQ_VECTOR    = 10'h008;
  localparam logic [7:0]  CTRL_RESET    = 8'h00;
  // Register offsets on the software port
  localparam logic [2:0]  OFS_WAKE_EN   = 3'h0;
  localparam logic [2:0]  OFS_IRQ_EN    = 3'h1;
  localparam logic [2:0]  OFS_FLAG      = 3'h2;
  localparam logic [2:0]  OFS_MASK      = 3'h3;
  localparam logic [2:0]  OFS_STATUS    = 3'h4;
  // Edges after reset before the change detector trusts its pipe
  localparam logic [1:0]  SYNC_FILL     = 2'h3;

  // Per-event decision given to the core
  typedef struct packed
  {
    logic wake;
    logic set_flag;
    logic vector;
    logic next_instr;
  } cmp_action_t;
endpackage : cmp_wake_pkg
`default_nettype wire

// >>> core/cmp_edge_sync.sv
// Two-flop synchroniser and change detector for the comparator output
`default_nettype none
module cmp_edge_sync
(
  input  wire logic ref_clk,
  input  wire logic srst,
  input  wire logic async_in,
  output logic      changed
);
  logic       meta_q;
  logic       meta_d;
  logic       sync_q;
  logic       sync_d;
  logic       last_q;
  logic       last_d;
  logic [1:0] fill_q;
  logic [1:0] fill_d;

  always_comb
  begin
    meta_d  = async_in;
    sync_d  = meta_q;
    last_d  = sync_q;
    fill_d  = fill_q;
    if (fill_q != cmp_wake_pkg::SYNC_FILL)
    begin
      fill_d = fill_q + 2'h1;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      meta_q  <= 1'b0;
      sync_q  <= 1'b0;
      last_q  <= 1'b0;
      fill_q  <= 2'h0;
    end
    else
    begin
      meta_q  <= meta_d;
      sync_q  <= sync_d;
      last_q  <= last_d;
      fill_q  <= fill_d;
    end
  end

  // Pipe refills after reset, so an idle-high pin is not a change
  assign changed = (fill_q == cmp_wake_pkg::SYNC_FILL) &&
                   (sync_q != last_q);
endmodule : cmp_edge_sync
`default_nettype wire

// >>> dv/cmp_wake_properties.sv
// Port assertions for the comparator wake block
`default_nettype none
module cmp_wake_properties
(
  input wire logic                      ref_clk,
  input wire logic                      srst,
  input wire cmp_wake_pkg::power_mode_t power_mode,
  input wire logic                      irq,
  input wire logic                      wake_req,
  input wire logic                      vector_req,
  input wire logic                      next_instr,
  input wire logic [9:0]                vector_addr,
  input wire logic                      clock_hold
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (srst);
  wire logic run = power_mode >= cmp_wake_pkg::MODE_GREEN;
  AST_IRQ_RUN:
    assert property (irq |-> run) else $error("irq in low power");
  AST_HOLD_NO_WAKE:
    assert property (clock_hold |-> !wake_req) else $error("wake held");
  AST_VEC_OR_NEXT:
    assert property (vector_req |-> !next_instr) else $error("both paths");
  AST_VEC_ADDR:
    assert property (vector_addr == 10'h008) else $error("vector addr");
  AST_WAKE_PATH:
    assert property (wake_req |-> (vector_req || next_instr))
      else $error("wake without a resume path");
  AST_WAKE_LOWPWR:
    assert property (wake_req |-> $past(power_mode) <= 2'h1)
      else $error("wake in run mode");
  cover property (wake_req && vector_req);
  cover property (wake_req && next_instr);
  cover property (irq);
endmodule : cmp_wake_properties
`default_nettype wire

// >>> dv/test_comparator_wake_interrupt.sv
// Self-checking bench for the comparator wake block
`default_nettype none
module test_comparator_wake_interrupt;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 0, srst = 1, cmp_out = 0, gie_set = 0, gie_clr = 0;
  logic reg_wr = 0, reg_rd = 0, irq, wake_req, vector_req, next_instr;
  logic clock_hold;
  logic [2:0] reg_addr = 0;
  logic [7:0] reg_wdata = 0, reg_rdata, rd_val;
  logic [9:0] vector_addr;
  logic [5:0] r;
  cmp_wake_pkg::power_mode_t power_mode = cmp_wake_pkg::MODE_NORMAL;
  int fail_count = 0, cmp_count = 0, seed = 32'hb8bf, i;
  always #5 ref_clk = ~ref_clk;
  comparator_wake_interrupt u_dut
  (.ref_clk, .srst, .cmp_out, .power_mode, .reg_addr, .reg_wdata,
   .global_irq_enable_instr(gie_set), .global_irq_disable_instr(gie_clr),
   .reg_wr, .reg_rd, .reg_rdata, .irq, .wake_req, .vector_req,
   .next_instr, .vector_addr, .clock_hold);
  task automatic end_of_test();
    if (fail_count == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : end_of_test
  task automatic chk(input string nm, input logic [7:0] e, g);
    cmp_count++;
    if (g !== e)
    begin
      fail_count++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  // Leading edge keeps strobe drops and raises in separate steps
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [2:0] a);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(negedge ref_clk);
    rd_val = reg_rdata;
  endtask : rd
  task automatic scen(input logic [1:0] m, input logic we, ie, g, mk);
    logic lp;
    logic [7:0] e, seen;
    lp = m <= 2'h1;
    @(posedge ref_clk);
    power_mode <= cmp_wake_pkg::power_mode_t'(m);
    gie_set <= g;
    gie_clr <= !g;
    @(posedge ref_clk);
    gie_set <= 1'b0;
    gie_clr <= 1'b0;
    wr(3'h0, {5'h0, we, 2'h0});
    wr(3'h1, {7'h0, ie});
    wr(3'h3, {7'h0, mk});
    wr(3'h4, 8'h01);
    @(posedge ref_clk);
    cmp_out <= ~cmp_out;
    seen = 8'h00;
    // Pulses last one cycle, so collect over the whole latency
    repeat (7)
    begin
      @(negedge ref_clk);
      seen = seen | {4'h0, wake_req, vector_req, next_instr,
                     wake_req & clock_hold};
    end
    e = {4'h0, lp & we, ie & g & (!lp | we), 2'b00};
    e[1] = (lp & we & !ie) | (ie & !g & (!lp | we));
    chk("pulses", e, seen);
    chk("irq", {7'h0, ie & mk & !lp}, {7'h0, irq});
    chk("hold", {7'h0, lp}, {7'h0, clock_hold});
    rd(3'h4);
    chk("status", {5'h0, lp, g, ie}, rd_val);
    rd(3'h0);
    chk("wake_en", {5'h0, we, 2'h0}, rd_val);
  endtask : scen
  initial
  begin
    repeat (4) @(posedge ref_clk);
    srst <= 1'b0;
    rd(3'h5);
    chk("unmapped", 8'h00, rd_val);
    chk("vector", 8'h08, vector_addr[7:0]);
    for (i = 0; i < 48; i++)
    begin
      r = (i < 32) ? {i[0], i[4:0]} : 6'($random(seed));
      scen(r[4:3], r[2], r[1], r[0], r[5]);
    end
    // Reset in mid-run must drop irq-enable, flag and global enable
    @(posedge ref_clk);
    power_mode <= cmp_wake_pkg::MODE_NORMAL;
    srst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    srst <= 1'b0;
    rd(3'h4);
    chk("rst_status", 8'h00, rd_val);
    rd(3'h1);
    chk("rst_irq_en", 8'h00, rd_val);
    end_of_test();
  end
  initial
  begin
    #100000;
    fail_count++;
    end_of_test();
  end
endmodule : test_comparator_wake_interrupt
bind comparator_wake_interrupt cmp_wake_properties u_props
(.ref_clk, .srst, .power_mode, .irq, .wake_req, .vector_req, .next_instr,
 .vector_addr, .clock_hold);
`default_nettype wire
